// ==== hw/adc_seq0_input_select.sv ====
// Purpose: Sequencer-zero per-sample channel selection with APB registers.
// Assumes: A single clock; converter timing is a fixed count.
//          The converter itself sits outside this block.
// Notes: A trigger input runs one sequence of up to eight positions.
//        Gap bits read as zero and writes to them are dropped.
`timescale 1ns/1ps

// Summary of operation
// R1: One 32-bit select register holds eight per-position channel fields.
// R2: Bits 29:28 choose the channel for the eighth position.
// R3: Field value is the analog channel number converted.
// R4: Bits 25:24 choose the channel for the seventh position.
// R5: Bits 21:20 choose the channel for the sixth position.
// R6: Bits 17:16 choose the channel for the fifth position.
// R7: Bits 13:12 choose the channel for the fourth position.
// R8: Bits 9:8 choose the channel for the third position.
// R9: Bits 5:4 choose the channel for the second position.
// R10: Bits 1:0 choose the channel for the first position.
// R11: Gap bits are read-only; software leaves them unchanged.
// R12: Differential position converts input pair 2i and 2i+1.
// R13: Temperature option converts the sensor instead of the field.
// R14: Positions after the last-flagged one are never converted.
// R15: Field is sampled when its position's conversion begins.
module adc_seq0_input_select (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [adc_seq0_pkg::ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic seqTrigger,
    output logic convStart,
    output logic [1:0] convSource,
    output logic [2:0] convChannel,
    output logic [2:0] convPosition,
    output logic seqBusy,
    output logic seqDone
);
    import adc_seq0_pkg::*;

    // Registers seen by software
    logic [31:0] seq0_sample_input_select;
    logic [31:0] next_seq0_sample_input_select;
    logic [31:0] sampleControl;
    logic [31:0] next_sampleControl;
    logic [31:0] next_prdata;
    logic next_pready;
    logic next_pslverr;
    logic [7:0] convCount;
    logic [7:0] next_convCount;

    // Sequencer state and registered outputs
    seq_state_e state;
    seq_state_e next_state;
    logic [2:0] pos;
    logic [2:0] next_pos;
    logic [3:0] timer;
    logic [3:0] next_timer;
    logic next_convStart;
    logic [1:0] next_convSource;
    logic [2:0] next_convChannel;
    logic [2:0] next_convPosition;
    logic next_seqBusy;
    logic next_seqDone;
    // Decode of the position in hand
    logic [SEL_W-1:0] curField;
    logic curTemp;
    logic curDiff;
    logic curLast;

    function automatic logic [1:0] selField(input logic [31:0] r,
                                            input logic [2:0] p);
        selField = 2'h0;
        // Case per position keeps each field's place explicit
        case (p)
            3'h0: begin
                // R10 first position
                selField = r[SEL0_LSB +: SEL_W];
            end
            3'h1: begin
                // R9 second position
                selField = r[SEL1_LSB +: SEL_W];
            end
            3'h2: begin
                // R8 third position
                selField = r[SEL2_LSB +: SEL_W];
            end
            3'h3: begin
                // R7 fourth position
                selField = r[SEL3_LSB +: SEL_W];
            end
            3'h4: begin
                // R6 fifth position
                selField = r[SEL4_LSB +: SEL_W];
            end
            3'h5: begin
                // R5 sixth position
                selField = r[SEL5_LSB +: SEL_W];
            end
            3'h6: begin
                // R4 seventh position
                selField = r[SEL6_LSB +: SEL_W];
            end
            3'h7: begin
                // R2 eighth position
                selField = r[SEL7_LSB +: SEL_W];
            end
            default: begin
                selField = 2'h0;
            end
        endcase
    endfunction : selField

    // Control word packs three option bits per position, four bits apart
    function automatic logic ctlBit(input logic [31:0] r,
                                    input logic [2:0] p,
                                    input int b);
        ctlBit = r[5'(int'(p) * FIELD_STRIDE + b)];
    endfunction : ctlBit

    // Pready gates the access so each transfer is taken once
    logic access;
    assign access = psel && penable && !pready;

    // Bus slave: one wait state, pready pulses for one cycle
    always_comb begin
        next_seq0_sample_input_select = seq0_sample_input_select;
        next_sampleControl = sampleControl;
        // Read data stays zero outside the answer cycle
        next_prdata = 32'h00000000;
        next_pready = 1'b0;
        next_pslverr = 1'b0;
        if (access) begin
            next_pready = 1'b1;
            if (paddr == SEL_OFFSET) begin
                if (pwrite) begin
                    // R1 R11 gap bits not stored
                    next_seq0_sample_input_select = pwdata & SEL_MASK;
                end else begin
                    next_prdata = seq0_sample_input_select;
                end
            end else if (paddr == CTL_OFFSET) begin
                if (pwrite) begin
                    // Local layout: differential, last, spare, temp
                    next_sampleControl = pwdata & CTL_MASK;
                end else begin
                    next_prdata = sampleControl;
                end
            end else if (paddr == CONV_OFFSET) begin
                if (pwrite) begin
                    // Counter is read-only; a write is refused
                    next_pslverr = 1'b1;
                end else begin
                    next_prdata = {24'h000000, convCount};
                end
            end else begin
                // Unmapped address: error, nothing changes
                next_pslverr = 1'b1;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            seq0_sample_input_select <= SEL_RESET;
            sampleControl <= CTL_RESET;
            prdata <= 32'h00000000;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            seq0_sample_input_select <= next_seq0_sample_input_select;
            sampleControl <= next_sampleControl;
            prdata <= next_prdata;
            pready <= next_pready;
            pslverr <= next_pslverr;
        end
    end

    // Option bits and field of the position in hand,
    // decoded once for the walk and the request
    always_comb begin
        curField = selField(seq0_sample_input_select, pos);
        curTemp = ctlBit(sampleControl, pos, CTL_TEMP_BIT);
        curDiff = ctlBit(sampleControl, pos, CTL_DIFF_BIT);
        curLast = ctlBit(sampleControl, pos, CTL_LAST_BIT);
    end

    // Sequencer walking the positions
    always_comb begin
        next_state = state;
        next_pos = pos;
        next_timer = timer;
        next_seqBusy = seqBusy;
        next_seqDone = 1'b0;
        case (state)
            IDLE: begin
                // Trigger ignored unless idle
                if (seqTrigger) begin
                    next_pos = 3'h0;
                    next_seqBusy = 1'b1;
                    next_state = START;
                end
            end
            START: begin
                // Timer covers the converter's busy cycles
                next_timer = CONV_COUNT;
                next_state = CONVERT;
            end
            CONVERT: begin
                // With no last flag the run stops after eight
                if (timer != 4'h0) begin
                    next_timer = timer - 4'h1;
                end else if (curLast || pos == 3'(SAMPLES - 1)) begin
                    // R14 stop at last flag
                    next_seqBusy = 1'b0;
                    next_seqDone = 1'b1;
                    next_state = IDLE;
                end else begin
                    next_pos = pos + 3'h1;
                    next_state = START;
                end
            end
            default: begin
                next_state = IDLE;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            state <= IDLE;
            pos <= 3'h0;
            timer <= 4'h0;
            seqBusy <= 1'b0;
            seqDone <= 1'b0;
        end else begin
            state <= next_state;
            pos <= next_pos;
            timer <= next_timer;
            seqBusy <= next_seqBusy;
            seqDone <= next_seqDone;
        end
    end

    // Source, channel and position hold until the next position starts; convStart pulses
    always_comb begin
        next_convStart = 1'b0;
        next_convSource = convSource;
        next_convChannel = convChannel;
        next_convPosition = convPosition;
        if (state == START) begin
            // R15 field taken at start
            next_convStart = 1'b1;
            next_convPosition = pos;
            // Sensor has no pair, so it wins over differential
            if (curTemp) begin
                // R13 sensor overrides field
                next_convSource = SRC_TEMP;
                next_convChannel = 3'h0;
            end else if (curDiff) begin
                // R12 pair 2i and 2i+1
                next_convSource = SRC_DIFF;
                next_convChannel = {curField, 1'b0};
            end else begin
                // R3 value names channel
                next_convSource = SRC_SINGLE;
                next_convChannel = {1'b0, curField};
            end
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            convStart <= 1'b0;
            convSource <= SRC_SINGLE;
            convChannel <= 3'h0;
            convPosition <= 3'h0;
        end else begin
            convStart <= next_convStart;
            convSource <= next_convSource;
            convChannel <= next_convChannel;
            convPosition <= next_convPosition;
        end
    end

    // Counter wraps; software reads it modulo 256
    always_comb begin
        next_convCount = convCount;
        if (state == START) begin
            next_convCount = convCount + 8'h01;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            convCount <= 8'h00;
        end else begin
            convCount <= next_convCount;
        end
    end
endmodule : adc_seq0_input_select

// ==== hw/adc_seq0_pkg.sv ====
// Purpose: Constants for the sequencer-zero input selection block.
// Assumes: APB with 32-bit data, byte addresses.
// Notes: One word per register; reserved bits read as zero.
package adc_seq0_pkg;
    localparam int ADDR_W = 12;
    localparam int SAMPLES = 8;
    localparam int SEL_W = 2;
    localparam int FIELD_STRIDE = 4;
    // Select field positions, one per sample position
    localparam int SEL0_LSB = 0;
    localparam int SEL1_LSB = 4;
    localparam int SEL2_LSB = 8;
    localparam int SEL3_LSB = 12;
    localparam int SEL4_LSB = 16;
    localparam int SEL5_LSB = 20;
    localparam int SEL6_LSB = 24;
    localparam int SEL7_LSB = 28;
    localparam logic [11:0] SEL_OFFSET = 12'h040;
    localparam logic [11:0] CTL_OFFSET = 12'h044;
    localparam logic [11:0] CONV_OFFSET = 12'h048;
    localparam logic [31:0] SEL_RESET = 32'h00000000;
    localparam logic [31:0] CTL_RESET = 32'h00000000;
    localparam logic [31:0] SEL_MASK = 32'h33333333;
    // Control word: per position bit 4n diff, 4n+1 last, 4n+3 temp
    localparam int CTL_DIFF_BIT = 0;
    localparam int CTL_LAST_BIT = 1;
    localparam int CTL_TEMP_BIT = 3;
    localparam logic [31:0] CTL_MASK = 32'hBBBBBBBB;
    // Conversion source codes
    localparam logic [1:0] SRC_SINGLE = 2'h0;
    localparam logic [1:0] SRC_DIFF = 2'h1;
    localparam logic [1:0] SRC_TEMP = 2'h2;
    localparam int CONV_CYCLES = 4;
    localparam logic [3:0] CONV_COUNT = 4'(CONV_CYCLES - 1);
    typedef enum logic [2:0] {
        IDLE = 3'b001,
        START = 3'b010,
        CONVERT = 3'b100
    } seq_state_e;
endpackage : adc_seq0_pkg

// ==== dv/adc_seq0_input_select_props.sv ====
// Purpose: Port checks for the input selection block.
// Assumes: One clock, synchronous reset.
// Notes: Gap bits are taken to read as zero.
`timescale 1ns/1ps
module adc_seq0_input_select_props (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic [adc_seq0_pkg::ADDR_W-1:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic seqTrigger,
    input wire logic convStart,
    input wire logic [1:0] convSource,
    input wire logic [2:0] convChannel,
    input wire logic seqBusy,
    input wire logic seqDone
);
    import adc_seq0_pkg::*;
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);
    AST_READY_WAIT: assert property (
        psel && penable && !pready |=> pready) else $error("late ready");
    AST_READY_PULSE: assert property (
        pready |=> !pready) else $error("ready too long");
    AST_ERR_WITH_READY: assert property (
        pslverr |-> pready) else $error("stray error");
    AST_RDATA_IDLE: assert property (
        !pready |-> prdata == 32'h00000000) else $error("stray read data");
    AST_GAP_ZERO: assert property (
        pready && paddr == SEL_OFFSET |-> (prdata & ~SEL_MASK) == 0)
        else $error("gap bits set");
    AST_TRIG_START: assert property (
        !seqBusy && seqTrigger |=> seqBusy ##1 convStart)
        else $error("no start");
    AST_CONV_SPACING: assert property (
        convStart |=> !convStart [*3] ##1
            (seqDone or (!convStart ##1 convStart)))
        else $error("bad spacing");
    AST_DONE_IDLE: assert property (
        seqDone |-> !seqBusy && !convStart) else $error("done while busy");
    AST_DIFF_EVEN: assert property (
        convStart && convSource == SRC_DIFF |-> !convChannel[0])
        else $error("odd pair");
    AST_TEMP_CHAN: assert property (
        convStart && convSource == SRC_TEMP |-> convChannel == 3'h0)
        else $error("temp channel");
endmodule : adc_seq0_input_select_props

// ==== dv/adc_seq0_input_select_tb.sv ====
// Purpose: Self-checking bench for the input selection block.
// Assumes: One wait state APB answers.
// Notes: Conversions are logged at each start pulse.
`timescale 1ns/1ps
`define CHK(a, b) begin nCompared++; if ((a) !== (b)) begin failCount++; \
    $display("unexpected at %0t: mismatch", $time); end end
module adc_seq0_input_select_tb;
    import adc_seq0_pkg::*;
    logic clk = 0, sys_rst = 1, psel = 0, penable = 0, pwrite = 0;
    logic seqTrigger = 0, pready, pslverr, convStart, seqBusy, seqDone, err;
    logic [ADDR_W-1:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata, rd;
    logic [1:0] convSource;
    logic [2:0] convChannel, convPosition;
    logic [7:0] q[$];
    int failCount = 0, nCompared = 0, cycles = 0;
    adc_seq0_input_select dut (.clk(clk), .sys_rst(sys_rst), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .seqTrigger(seqTrigger), .convStart(convStart),
        .convSource(convSource), .convChannel(convChannel),
        .convPosition(convPosition), .seqBusy(seqBusy), .seqDone(seqDone));
    initial forever #20 clk = ~clk;
    always @(posedge clk) begin
        cycles++;
        if (convStart === 1'b1)
            q.push_back({convPosition, convSource, convChannel});
        if (cycles == 2000) begin
            failCount++;
            conclude();
        end
    end
    task automatic conclude();
        if (failCount == 0 && nCompared > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : conclude
    task automatic apb(input logic w, input logic [11:0] a,
            input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) @(posedge clk);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic runSeq(input logic live, input logic [31:0] v);
        q.delete();
        @(posedge clk);
        seqTrigger <= 1'b1;
        @(posedge clk);
        seqTrigger <= 1'b0;
        // Optional select write landing while position 0 converts
        if (live) apb(1, SEL_OFFSET, v);
        repeat (80) if (seqDone !== 1'b1) @(posedge clk);
    endtask : runSeq
    task automatic testRegs();
        apb(0, SEL_OFFSET, 0);
        `CHK(rd, SEL_RESET)
        apb(1, SEL_OFFSET, 32'hFFFFFFFF);
        apb(0, SEL_OFFSET, 0);
        `CHK(rd, SEL_MASK)
        apb(1, CTL_OFFSET, 32'hFFFFFFFF);
        apb(0, CTL_OFFSET, 0);
        `CHK(rd, CTL_MASK)
        apb(0, 12'h04C, 0);
        `CHK(err, 1'b1)
        `CHK(rd, 32'h00000000)
        apb(1, CONV_OFFSET, 32'h000000FF);
        `CHK(err, 1'b1)
    endtask : testRegs
    task automatic testFields();
        apb(1, SEL_OFFSET, 32'h32103210);
        apb(1, CTL_OFFSET, 0);
        runSeq(0, 0);
        `CHK(q.size(), 8)
        for (int i = 0; i < 8; i++)
            `CHK(q[i], {3'(i), SRC_SINGLE, 3'(i % 4)})
    endtask : testFields
    task automatic testOptions();
        // Nonzero fields past the last position must stay unused
        apb(1, SEL_OFFSET, 32'h33333323);
        apb(1, CTL_OFFSET, 32'h000000A1);
        runSeq(0, 0);
        `CHK(q.size(), 2)
        `CHK(q[0], {3'h0, SRC_DIFF, 3'h6})
        `CHK(q[1], {3'h1, SRC_TEMP, 3'h0})
        // Ten conversions so far: eight plus two
        apb(0, CONV_OFFSET, 0);
        `CHK(rd, 32'h0000000A)
    endtask : testOptions
    task automatic testLive();
        // A write during a run reaches later positions only
        apb(1, SEL_OFFSET, 0);
        apb(1, CTL_OFFSET, 0);
        runSeq(1, 32'h11111111);
        `CHK(q.size(), 8)
        `CHK(q[0], {3'h0, SRC_SINGLE, 3'h0})
        `CHK(q[7], {3'h7, SRC_SINGLE, 3'h1})
    endtask : testLive
    initial begin
        repeat (5) @(posedge clk);
        sys_rst <= 1'b0;
        testRegs();
        testFields();
        testOptions();
        testLive();
        conclude();
    end
endmodule : adc_seq0_input_select_tb
bind adc_seq0_input_select adc_seq0_input_select_props chk (.clk(clk),
    .sys_rst(sys_rst), .psel(psel), .penable(penable), .paddr(paddr),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .seqTrigger(seqTrigger), .convStart(convStart), .convSource(convSource),
    .convChannel(convChannel), .seqBusy(seqBusy), .seqDone(seqDone));
